// *** rtl/tmoc_pkg.sv ***
// Constants, types and decode functions for the timer compare unit.
// What this block does
// - Compare counter with each channel continuously
// - Match sets flag next tick, requests interrupt
// - Flag clears on service or written one
// - PWM modes buffer compare, load at top/bottom
// - Compare access hits buffer or active register
// - Force strobe acts like match, non-PWM only
// - Counter write blocks matches next tick
// - Output state kept across mode changes
// - Action field unbuffered, applies next match
// - Nonzero action field overrides port value
// - Override visible only with direction output
// - Action zero leaves output state unchanged
// - Counting depends only on waveform mode
// - Action selects polarity or set/clear/toggle
// - Mode zero counts up, wraps FF to 00
// - Normal overflow flag set as counter zeroes
// - Counter writable any time in normal mode
// - Bottom 00, max FF, top max or A
// - Counter write beats clear or count
// - Mode two is clear-on-match, unbuffered, forcible
// - Modes three, seven fast PWM, buffered
package tmoc_pkg;

  localparam int NUM_CHAN = 2;
  localparam int ADDR_W = 8;

  localparam logic [7:0] OFS_COUNTER = 8'h00;
  localparam logic [7:0] OFS_COMPARE_A = 8'h04;
  localparam logic [7:0] OFS_COMPARE_B = 8'h08;
  localparam logic [7:0] OFS_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_FORCE = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;

  localparam int CTL_WGM_LSB = 0;
  localparam int CTL_ACT_A_LSB = 4;
  localparam int CTL_ACT_B_LSB = 6;
  localparam int FLG_OVF = 0;
  localparam int FLG_A = 1;
  localparam int FLG_B = 2;

  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_CTC = 3'h2;

  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_ONE = 8'h01;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_FLAGS = 3'h0;

  typedef enum logic [1:0] {
    AP_IDLE = 2'b01,
    AP_DONE = 2'b10
  } tmoc_apb_state_type;

  typedef struct packed {
    logic [1:0] action;
    logic pwm;
    logic fast;
    logic down;
  } tmoc_chan_cfg_type;

  function automatic logic is_pwm(input logic [2:0] wgm);
    return wgm[0];
  endfunction

  function automatic logic is_fast(input logic [2:0] wgm);
    return wgm[1] & wgm[0];
  endfunction

  function automatic logic is_phase(input logic [2:0] wgm);
    return wgm[0] & ~wgm[1];
  endfunction

  function automatic logic top_is_a(input logic [2:0] wgm);
    return (wgm == WGM_CTC) | (wgm[2] & wgm[0]);
  endfunction

endpackage

// *** rtl/tmoc_channel.sv ***
// One compare channel: compare register, match detect and output state.
`timescale 1ns/1ns
module tmoc_channel
  import tmoc_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Timer state.
  input wire logic tick,
  input wire logic [7:0] cnt,
  input wire logic block,
  input wire logic buf_load,
  input wire logic bottom_evt,
  input wire tmoc_chan_cfg_type cfg,
  // Software access.
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic force_strobe,
  // Results.
  output logic match_evt,
  output logic [7:0] active,
  output logic [7:0] read_val,
  output logic oc
);

  logic [7:0] active_r;
  logic [7:0] buf_r;
  logic oc_r;
  logic oc_nxt;
  logic hit;

  assign hit = (cnt == active_r);
  assign match_evt = tick & hit & ~block;
  assign active = active_r;
  assign read_val = cfg.pwm ? buf_r : active_r;
  assign oc = oc_r;

  // Buffer and active compare registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_r <= RST_BYTE;
    end else if (wr_en) begin
      buf_r <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_r <= RST_BYTE;
    end else if (wr_en && !cfg.pwm) begin
      active_r <= wr_data;
    end else if (buf_load && cfg.pwm) begin
      active_r <= buf_r;
    end
  end

  // Output state update; action zero never changes it.
  always_comb begin
    oc_nxt = oc_r;
    if (!cfg.pwm) begin
      if (match_evt || force_strobe) begin
        case (cfg.action)
          ACT_TOGGLE: oc_nxt = ~oc_r;
          ACT_CLEAR: oc_nxt = 1'b0;
          ACT_SET: oc_nxt = 1'b1;
          default: oc_nxt = oc_r;
        endcase
      end
    end else if (match_evt) begin
      case (cfg.action)
        ACT_TOGGLE: oc_nxt = ~oc_r;
        ACT_CLEAR: oc_nxt = cfg.down;
        ACT_SET: oc_nxt = ~cfg.down;
        default: oc_nxt = oc_r;
      endcase
    end else if (bottom_evt && cfg.fast) begin
      case (cfg.action)
        ACT_CLEAR: oc_nxt = 1'b1;
        ACT_SET: oc_nxt = 1'b0;
        default: oc_nxt = oc_r;
      endcase
    end
  end

  // Not reset by mode changes, only by the global reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_r <= 1'b0;
    end else begin
      oc_r <= oc_nxt;
    end
  end

  a_force_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    force_strobe && !cfg.pwm && cfg.action == ACT_TOGGLE && !match_evt
    |=> oc_r != $past(oc_r))
    else $error("force strobe did not toggle output state");

  a_force_pwm: assert property (@(posedge pclk) disable iff (!presetn)
    force_strobe && cfg.pwm && !match_evt && !bottom_evt
    |=> $stable(oc_r))
    else $error("force strobe changed output state in PWM mode");

  a_action_none: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.action == ACT_NONE |=> $stable(oc_r))
    else $error("output state changed with action none");

  a_direct_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && !cfg.pwm |=> active_r == $past(wr_data))
    else $error("unbuffered compare write not applied");

  a_buffered_hold: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr_en && cfg.pwm && !buf_load |=> $stable(active_r))
    else $error("buffered compare write reached active register");

endmodule

// *** rtl/tmoc_top.sv ***
// Timer counter with two output compare channels behind an APB slave.
`timescale 1ns/1ns
module tmoc_top
  import tmoc_pkg::*;
(
  // Clock, reset and timer clock enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic timer_tick,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt service acknowledge, one bit per flag.
  input wire logic [2:0] irq_ack,
  // Interrupt requests, one bit per flag.
  output logic [2:0] irq_req,
  // Port logic for the two compare pins.
  input wire logic [NUM_CHAN-1:0] port_value,
  input wire logic [NUM_CHAN-1:0] output_pin_direction_bit,
  output logic [NUM_CHAN-1:0] pin_out,
  output logic [NUM_CHAN-1:0] pin_oe
);

  tmoc_apb_state_type apb_state_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [7:0] counter_value_r;
  logic [7:0] counter_value_nxt;
  logic count_down_r;
  logic count_down_nxt;
  logic block_r;
  logic [2:0] waveform_mode_field_r;
  logic [1:0] output_action_field_r [NUM_CHAN];
  logic [2:0] flags_r;
  logic [2:0] irq_en_r;
  logic [2:0] irq_req_r;
  logic [NUM_CHAN-1:0] force_match_strobe_r;
  logic [NUM_CHAN-1:0] pin_out_r;
  logic [NUM_CHAN-1:0] pin_oe_r;

  logic apb_commit;
  logic apb_wr;
  logic apb_mapped;
  logic cnt_wr;
  logic ctl_wr;
  logic [NUM_CHAN-1:0] cmp_wr;
  logic [7:0] wbyte;
  logic [7:0] top_value;
  logic at_top;
  logic mode_pwm;
  logic mode_fast;
  logic mode_phase;
  logic overflow_evt;
  logic buf_load;
  logic bottom_evt;
  logic [NUM_CHAN-1:0] match_evt;
  logic [NUM_CHAN-1:0] chan_oc;
  logic [7:0] chan_active [NUM_CHAN];
  logic [7:0] chan_read [NUM_CHAN];
  logic [31:0] rdata_nxt;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  // APB decode.
  assign apb_commit = psel & penable & pready_r;
  assign apb_wr = apb_commit & pwrite & pstrb[0];
  assign wbyte = pwdata[7:0];
  assign cnt_wr = apb_wr && paddr == OFS_COUNTER;
  assign ctl_wr = apb_wr && paddr == OFS_CONTROL;
  assign cmp_wr[0] = apb_wr && paddr == OFS_COMPARE_A;
  assign cmp_wr[1] = apb_wr && paddr == OFS_COMPARE_B;

  always_comb begin
    apb_mapped = 1'b1;
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      OFS_COUNTER: rdata_nxt[7:0] = counter_value_r;
      OFS_COMPARE_A: rdata_nxt[7:0] = chan_read[0];
      OFS_COMPARE_B: rdata_nxt[7:0] = chan_read[1];
      OFS_CONTROL: begin
        rdata_nxt[CTL_WGM_LSB +: 3] = waveform_mode_field_r;
        rdata_nxt[CTL_ACT_A_LSB +: 2] = output_action_field_r[0];
        rdata_nxt[CTL_ACT_B_LSB +: 2] = output_action_field_r[1];
      end
      OFS_FORCE: rdata_nxt = 32'h0000_0000;
      OFS_FLAGS: rdata_nxt[2:0] = flags_r;
      OFS_IRQ_EN: rdata_nxt[2:0] = irq_en_r;
      default: apb_mapped = 1'b0;
    endcase
  end

  // One wait state: answer is prepared in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state_r <= AP_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      case (apb_state_r)
        AP_IDLE: begin
          if (psel && penable) begin
            apb_state_r <= AP_DONE;
            pready_r <= 1'b1;
            pslverr_r <= ~apb_mapped;
            prdata_r <= pwrite ? 32'h0000_0000 : rdata_nxt;
          end
        end
        AP_DONE: begin
          apb_state_r <= AP_IDLE;
          pready_r <= 1'b0;
          pslverr_r <= 1'b0;
        end
        default: begin
          apb_state_r <= AP_IDLE;
          pready_r <= 1'b0;
          pslverr_r <= 1'b0;
        end
      endcase
    end
  end

  // Control register; action fields take effect without buffering.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waveform_mode_field_r <= WGM_NORMAL;
      output_action_field_r[0] <= ACT_NONE;
      output_action_field_r[1] <= ACT_NONE;
    end else if (ctl_wr) begin
      waveform_mode_field_r <= pwdata[CTL_WGM_LSB +: 3];
      output_action_field_r[0] <= pwdata[CTL_ACT_A_LSB +: 2];
      output_action_field_r[1] <= pwdata[CTL_ACT_B_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= RST_FLAGS;
    end else if (apb_wr && paddr == OFS_IRQ_EN) begin
      irq_en_r <= pwdata[2:0];
    end
  end

  // Force strobes are one-cycle pulses after the write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_match_strobe_r <= '0;
    end else if (apb_wr && paddr == OFS_FORCE) begin
      force_match_strobe_r <= pwdata[NUM_CHAN-1:0];
    end else begin
      force_match_strobe_r <= '0;
    end
  end

  // Counting sequence from the waveform mode only.
  assign mode_pwm = is_pwm(waveform_mode_field_r);
  assign mode_fast = is_fast(waveform_mode_field_r);
  assign mode_phase = is_phase(waveform_mode_field_r);
  assign top_value = top_is_a(waveform_mode_field_r) ? chan_active[0]
                                                     : CNT_MAX;
  assign at_top = counter_value_r == top_value;

  always_comb begin
    counter_value_nxt = counter_value_r;
    count_down_nxt = count_down_r;
    if (cnt_wr) begin
      counter_value_nxt = wbyte;
    end else if (timer_tick) begin
      if (mode_phase) begin
        if (!count_down_r && at_top) begin
          count_down_nxt = 1'b1;
          counter_value_nxt = counter_value_r - CNT_ONE;
        end else if (count_down_r && counter_value_r == CNT_BOTTOM) begin
          count_down_nxt = 1'b0;
          counter_value_nxt = counter_value_r + CNT_ONE;
        end else if (count_down_r) begin
          counter_value_nxt = counter_value_r - CNT_ONE;
        end else begin
          counter_value_nxt = counter_value_r + CNT_ONE;
        end
      end else if (waveform_mode_field_r == WGM_NORMAL) begin
        counter_value_nxt = counter_value_r + CNT_ONE;
      end else if (at_top) begin
        counter_value_nxt = CNT_BOTTOM;
      end else begin
        counter_value_nxt = counter_value_r + CNT_ONE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value_r <= CNT_BOTTOM;
      count_down_r <= 1'b0;
    end else begin
      counter_value_r <= counter_value_nxt;
      count_down_r <= mode_phase ? count_down_nxt : 1'b0;
    end
  end

  // A counter write blocks matches until the next tick has passed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_r <= 1'b0;
    end else if (cnt_wr) begin
      block_r <= 1'b1;
    end else if (timer_tick) begin
      block_r <= 1'b0;
    end
  end

  // Buffer load at top for phase correct, at wrap for fast PWM.
  assign bottom_evt = timer_tick & ~cnt_wr & mode_fast & at_top;
  assign buf_load = bottom_evt | (timer_tick & ~cnt_wr & mode_phase
                                  & ~count_down_r & at_top);

  always_comb begin
    overflow_evt = 1'b0;
    if (timer_tick && !cnt_wr) begin
      if (mode_fast) begin
        overflow_evt = at_top;
      end else if (mode_phase) begin
        overflow_evt = count_down_r && counter_value_r == CNT_BOTTOM;
      end else begin
        overflow_evt = counter_value_r == CNT_MAX;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
      tmoc_chan_cfg_type cfg;
      assign cfg.action = output_action_field_r[gi];
      assign cfg.pwm = mode_pwm;
      assign cfg.fast = mode_fast;
      assign cfg.down = count_down_r;
      tmoc_channel u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .tick(timer_tick),
        .cnt(counter_value_r),
        .block(block_r),
        .buf_load(buf_load),
        .bottom_evt(bottom_evt),
        .cfg(cfg),
        .wr_en(cmp_wr[gi]),
        .wr_data(wbyte),
        .force_strobe(force_match_strobe_r[gi]),
        .match_evt(match_evt[gi]),
        .active(chan_active[gi]),
        .read_val(chan_read[gi]),
        .oc(chan_oc[gi])
      );

      // Pin override and direction, registered.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_out_r[gi] <= 1'b0;
          pin_oe_r[gi] <= 1'b0;
        end else begin
          pin_out_r[gi] <= (output_action_field_r[gi] != ACT_NONE)
                           ? chan_oc[gi] : port_value[gi];
          pin_oe_r[gi] <= output_pin_direction_bit[gi];
        end
      end
    end
  endgenerate

  // Flags: hardware set wins over service or write-one clear.
  assign flag_set = {match_evt[1], match_evt[0], overflow_evt};
  assign flag_clr = irq_ack
                    | ((apb_wr && paddr == OFS_FLAGS) ? pwdata[2:0]
                                                      : RST_FLAGS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= RST_FLAGS;
    end else begin
      flags_r <= flag_set | (flags_r & ~flag_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_r <= RST_FLAGS;
    end else begin
      irq_req_r <= flags_r & irq_en_r;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq_req = irq_req_r;
  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;

  a_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
    match_evt[0] |=> flags_r[FLG_A] ##1 (irq_req_r[FLG_A] == irq_en_r[FLG_A]
    || $changed(irq_en_r)))
    else $error("match did not set flag or request");

  a_wr_block: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_wr && !timer_tick ##1 timer_tick |-> match_evt == '0)
    else $error("match not blocked after counter write");

  a_wr_priority: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_wr |=> counter_value_r == $past(wbyte))
    else $error("counter write lost");

  a_normal_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    timer_tick && !cnt_wr && waveform_mode_field_r == WGM_NORMAL
    && counter_value_r == CNT_MAX
    |=> counter_value_r == CNT_BOTTOM && flags_r[FLG_OVF])
    else $error("normal mode wrap or overflow flag wrong");

  a_normal_count: assert property (@(posedge pclk)
    disable iff (!presetn)
    timer_tick && !cnt_wr && waveform_mode_field_r == WGM_NORMAL
    |=> counter_value_r == $past(counter_value_r) + CNT_ONE)
    else $error("normal mode did not count up");

  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    irq_ack[FLG_B] && !match_evt[1] |=> !flags_r[FLG_B])
    else $error("serviced flag not cleared");

  a_pin_override: assert property (@(posedge pclk)
    disable iff (!presetn)
    output_action_field_r[0] != ACT_NONE |=> pin_out_r[0] == $past(chan_oc[0]))
    else $error("pin not driven by output state");

  a_pin_dir: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> pin_oe_r == $past(output_pin_direction_bit))
    else $error("pin direction not following direction bit");

  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready_r |=> pready_r ##1 !pready_r)
    else $error("APB answer not one wait state");

endmodule

// *** testbench/tmoc_port_model.sv ***
// Port pin model: port data and direction registers and the pad level.
`timescale 1ns/1ns
module tmoc_port_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Settings from the bench.
  input wire logic [1:0] set_value,
  input wire logic [1:0] set_dir,
  // Block side.
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  output logic [1:0] port_value,
  output logic [1:0] dir_bit,
  // Pad level, pulled up while nothing drives it.
  output logic [1:0] pad
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_value <= 2'h0;
      dir_bit <= 2'h0;
    end else begin
      port_value <= set_value;
      dir_bit <= set_dir;
    end
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pad[i] = pin_oe[i] ? pin_out[i] : 1'b1;
    end
  end
endmodule

// *** testbench/timer8_output_compare_unit_bench.sv ***
// Self-checking bench for the timer compare unit with a reference model.
`timescale 1ns/1ns
module timer8_output_compare_unit_bench
  import tmoc_pkg::*;
;
  logic pclk, presetn, timer_tick, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [2:0] irq_ack, irq_req;
  logic [1:0] port_value, dir_bit, pin_out, pin_oe, pad, set_value, set_dir;
  logic [15:0] lfsr;
  logic err;
  int mismatches, n_tests, v, w, m_cnt, m_wgm, m_flags, m_en, m_blk;
  int m_port, m_dir;
  int m_cmp[2], m_buf[2], m_act[2], m_oc[2];

  tmoc_top u_dut (.pclk(pclk), .presetn(presetn), .timer_tick(timer_tick),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_ack(irq_ack), .irq_req(irq_req),
    .port_value(port_value), .output_pin_direction_bit(dir_bit),
    .pin_out(pin_out), .pin_oe(pin_oe));
  tmoc_port_model u_port (.pclk(pclk), .presetn(presetn),
    .set_value(set_value), .set_dir(set_dir), .pin_out(pin_out),
    .pin_oe(pin_oe), .port_value(port_value), .dir_bit(dir_bit), .pad(pad));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
    chk_reg({30'h0, got}, {30'h0, exp});
  endtask

  function automatic void rnd(output int r);
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    r = lfsr[7:0];
  endfunction

  function automatic int act_apply(input int act, input int oc);
    case (act)
      1: return (oc ^ 1) & 1;
      2: return 0;
      3: return 1;
      default: return oc;
    endcase
  endfunction

  task automatic apb(input logic [ADDR_W-1:0] a, input logic wr,
                     input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      mismatches++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input int d);
    apb(a, 1'b1, d, 4'hF);
    case (a)
      OFS_COUNTER: begin
        m_cnt = d & 255;
        m_blk = 1;
      end
      OFS_COMPARE_A, OFS_COMPARE_B: begin
        m_buf[a[3]] = d & 255;
        if (!(m_wgm & 1)) m_cmp[a[3]] = d & 255;
      end
      OFS_CONTROL: begin
        m_wgm = d & 7;
        m_act[0] = (d >> 4) & 3;
        m_act[1] = (d >> 6) & 3;
      end
      OFS_FORCE: begin
        for (int c = 0; c < 2; c++) begin
          if (!(m_wgm & 1) && ((d >> c) & 1)) begin
            m_oc[c] = act_apply(m_act[c], m_oc[c]);
          end
        end
      end
      OFS_FLAGS: m_flags = m_flags & ~d;
      default: m_en = d & 7;
    endcase
  endtask

  task automatic reg_rd(input logic [ADDR_W-1:0] a, input int e);
    apb(a, 1'b0, 32'h0, 4'hF);
    chk_reg(rd, e);
  endtask

  task automatic tick();
    @(posedge pclk);
    timer_tick <= 1'b1;
    @(posedge pclk);
    timer_tick <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      if (!m_blk && m_cnt == m_cmp[c]) begin
        m_flags = m_flags | (2 << c);
        if (!(m_wgm & 1)) m_oc[c] = act_apply(m_act[c], m_oc[c]);
      end
    end
    if (m_cnt == 255) m_flags = m_flags | 1;
    if ((m_wgm & 1) && m_cnt == 255) m_cmp = m_buf;
    if (m_wgm == 2 && m_cnt == m_cmp[0]) m_cnt = 0;
    else m_cnt = (m_cnt + 1) & 255;
    m_blk = 0;
  endtask

  task automatic set_port(input int pv, input int dv);
    @(posedge pclk);
    set_value <= pv[1:0];
    set_dir <= dv[1:0];
    m_port = pv & 3;
    m_dir = dv & 3;
  endtask

  task automatic chk_pads();
    logic [1:0] po, pd;
    repeat (4) @(posedge pclk);
    #1;
    for (int i = 0; i < 2; i++) begin
      po[i] = (m_act[i] != 0) ? m_oc[i][0] : m_port[i];
      pd[i] = m_dir[i] ? po[i] : 1'b1;
    end
    chk_pin(pin_out, po);
    chk_pin(pad, pd);
    chk_pin(pin_oe, m_dir[1:0]);
  endtask

  initial begin
    {presetn, timer_tick, psel, penable, pwrite, err} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    rd = 32'h0;
    pstrb = 4'h0;
    irq_ack = 3'h0;
    set_value = 2'h0;
    set_dir = 2'h0;
    lfsr = 16'h3337;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 24; a += 4) reg_rd(a, 0);
    apb(8'h1C, 1'b0, 32'h0, 4'hF);
    chk_reg({31'h0, err}, 1);
    apb(OFS_COMPARE_A, 1'b1, 32'h55, 4'hE);
    reg_rd(OFS_COMPARE_A, 0);
    reg_wr(OFS_COUNTER, 'hFD);
    tick();
    tick();
    reg_rd(OFS_FLAGS, m_flags);
    tick();
    reg_rd(OFS_COUNTER, m_cnt);
    reg_rd(OFS_FLAGS, m_flags);
    rnd(v);
    v = 16 + v % 200;
    rnd(w);
    reg_wr(OFS_COMPARE_A, v);
    reg_wr(OFS_COMPARE_B, 16 + w % 200);
    reg_wr(OFS_IRQ_EN, 7);
    reg_wr(OFS_COUNTER, v);
    tick();
    reg_rd(OFS_FLAGS, m_flags);
    reg_wr(OFS_COUNTER, v - 1);
    tick();
    tick();
    reg_rd(OFS_FLAGS, m_flags);
    chk_reg({29'h0, irq_req}, m_flags & m_en);
    reg_wr(OFS_FLAGS, 2);
    reg_rd(OFS_FLAGS, m_flags);
    @(posedge pclk);
    irq_ack <= 3'h1;
    @(posedge pclk);
    irq_ack <= 3'h0;
    m_flags = m_flags & 6;
    reg_rd(OFS_FLAGS, m_flags);
    rnd(v);
    set_port(v, 0);
    reg_wr(OFS_CONTROL, 'hF0);
    reg_wr(OFS_FORCE, 3);
    chk_pads();
    set_port(v, 3);
    chk_pads();
    for (int md = 0; md <= 2; md += 2) begin
      for (int ac = 0; ac < 4; ac++) begin
        rnd(v);
        set_port(v, v >> 2);
        reg_wr(OFS_CONTROL, md | (ac << 4) | ((3 - ac) << 6));
        reg_wr(OFS_FORCE, 3);
        chk_pads();
        reg_rd(OFS_FLAGS, m_flags);
      end
    end
    set_port(v, 3);
    reg_wr(OFS_CONTROL, 'h53);
    reg_wr(OFS_FORCE, 3);
    chk_pads();
    rnd(v);
    reg_wr(OFS_COMPARE_A, v);
    reg_rd(OFS_COMPARE_A, m_buf[0]);
    reg_wr(OFS_CONTROL, 0);
    reg_rd(OFS_COMPARE_A, m_cmp[0]);
    reg_wr(OFS_CONTROL, 3);
    reg_wr(OFS_COUNTER, 'hFE);
    tick();
    tick();
    reg_wr(OFS_CONTROL, 0);
    reg_rd(OFS_COMPARE_A, m_cmp[0]);
    reg_rd(OFS_COUNTER, m_cnt);
    reg_rd(OFS_FLAGS, m_flags);
    reg_wr(OFS_CONTROL, 'h12);
    reg_wr(OFS_COMPARE_A, 3);
    repeat (4) tick();
    reg_rd(OFS_COUNTER, m_cnt);
    reg_rd(OFS_FLAGS, m_flags);
    chk_pads();
    report_and_stop();
  end
endmodule
